// file: hw/pcf_map.svh
// How it works
// - hardware reset clears every bit of the extension control register
// - extension bit 10 is an os-set flag for unmasked simd fault support
// - extension bit 9 is an os-set flag for fpu state save on switches
// - extension bit 5 set gives 36-bit physical addresses, clear limits to 32
// - extension bit 7 set keeps global translations across task switches
// - extension bit 8 set lets performance counter reads run at any privilege
// - virtual-8086 extension flag enables virtual interrupt flag in v86 mode
// - protected virtual interrupt flag enables virtual interrupt flag in protected mode
// - timestamp restrict flag allows timestamp reads only at privilege level 0
// - debug extension flag makes debug register 4 or 5 references fault
// - large page flag enables 4-MByte pages besides normal pages
// - machine-check enable flag raises machine-check on hardware errors
// - numeric error flag selects native reporting of numeric errors
// - write-protect flag blocks supervisor writes to read-only user pages
// - alignment checking only when alignment mask and check flag both set
// - no-write-through clear allows write-throughs and invalidations, set suppresses them
// - cache enabled while cache-off flag clear, disabled while set
// - paging on: page cache-off flag driven on its pin in unpaged cycles
// - paging on: page write-through flag driven on its pin in unpaged cycles
// - soft-float flag set traps float instructions, clear passes them to fpu
// - monitor flag set makes wait instructions test task-switched, clear ignores
// - emulation set: float instructions raise device-not-available, vector 7
`ifndef PCF_MAP_SVH
`define PCF_MAP_SVH

// ************************************************************
// system control zero bit positions
// ************************************************************
`define PCF_SCZ_PE   0
`define PCF_SCZ_MON  1
`define PCF_SCZ_SFT  2
`define PCF_SCZ_TSW  3
`define PCF_SCZ_NER  5
`define PCF_SCZ_WP   16
`define PCF_SCZ_ACM  18
`define PCF_SCZ_NWT  29
`define PCF_SCZ_COF  30
`define PCF_SCZ_PG   31
`define PCF_SCZ_WMASK 32'hE005002F
`define PCF_SCZ_RST   32'h00000000

// ************************************************************
// page base control bit positions
// ************************************************************
`define PCF_PBC_WRT   3
`define PCF_PBC_COF   4
`define PCF_PBC_WMASK 32'hFFFFF018
`define PCF_PBC_RST   32'h00000000

// ************************************************************
// extension control bit positions
// ************************************************************
`define PCF_EXT_V86  0
`define PCF_EXT_PIRQ 1
`define PCF_EXT_TSR  2
`define PCF_EXT_XBC  3
`define PCF_EXT_LPG  4
`define PCF_EXT_WPA  5
`define PCF_EXT_HWE  6
`define PCF_EXT_GPK  7
`define PCF_EXT_PCU  8
`define PCF_EXT_OSF  9
`define PCF_EXT_OSX  10
`define PCF_EXT_WMASK 32'h000007FF
`define PCF_EXT_RST   32'h00000000

// ************************************************************
// fault vectors and address widths
// ************************************************************
`define PCF_VEC_IOP  8'h06
`define PCF_VEC_NM   8'h07
`define PCF_VEC_GP   8'h0D
`define PCF_VEC_PF   8'h0E
`define PCF_VEC_MF   8'h10
`define PCF_VEC_ALN  8'h11
`define PCF_VEC_MC   8'h12
`define PCF_PA_NARROW 32

`endif

// file: hw/pcf_pkg.sv
package pcf_pkg;

	// ************************************************************
	// selectors and operation kinds
	// ************************************************************
	typedef enum logic [1:0] {PCF_SEL_SCZ, PCF_SEL_PBC, PCF_SEL_EXT} pcf_crsel_e;
	typedef enum logic [2:0] {
		PCF_OP_NONE, PCF_OP_FP, PCF_OP_WAIT, PCF_OP_PMC, PCF_OP_TSC, PCF_OP_DBG, PCF_OP_MEM
	} pcf_op_e;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic       valid;
		pcf_op_e    kind;
		logic [1:0] cpl;
		logic [2:0] dbg_idx;
		logic       misaligned;
		logic       alignment_check_flag;
		logic       sup_wr_ro_user;
	} pcf_op_s;

	typedef struct packed {
		logic       fault;
		logic [7:0] vector;
		logic       fpu_issue;
		logic [2:0] dbg_idx_eff;
	} pcf_verdict_s;

	typedef struct packed {
		logic v86_interrupt_ext;
		logic protected_virtual_irq;
		logic timestamp_read_restrict;
		logic extended_breakpoint_control;
		logic large_page_ext;
		logic wide_physical_address;
		logic hw_error_exception_on;
		logic global_page_keep;
		logic perf_counter_user_read;
		logic os_fpu_state_save;
		logic os_simd_fault_support;
		logic numeric_error_report;
		logic write_protect_on;
		logic alignment_check_mask;
	} pcf_mode_s;

	typedef struct packed {
		logic cache_enable;
		logic write_through_on;
		logic inval_cycles_on;
	} pcf_cache_s;

endpackage

// file: hw/pcf_gate.sv
`timescale 1ns/1ns
`include "pcf_map.svh"
module pcf_gate (
	input  wire  pcf_pkg::pcf_op_s      op,
	input  wire  logic [31:0]           scz,
	input  wire  logic [31:0]           ext,
	output       pcf_pkg::pcf_verdict_s verdict
);
	import pcf_pkg::*;

	// privilege above level 0, used by both counter checks
	function automatic logic user_level(input logic [1:0] cpl);
		user_level = (cpl != 2'h0);
	endfunction

	// ************************************************************
	// instruction gating against the control flags
	// ************************************************************
	always_comb begin
		verdict = '0;
		verdict.dbg_idx_eff = op.dbg_idx;
		if (op.valid) begin
			unique case (op.kind)
				PCF_OP_NONE: begin
				end
				PCF_OP_FP: begin
					if (scz[`PCF_SCZ_SFT]) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_NM;
					end else begin
						verdict.fpu_issue = 1'b1;
					end
				end
				PCF_OP_WAIT: begin
					if (scz[`PCF_SCZ_MON] && scz[`PCF_SCZ_TSW]) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_NM;
					end
				end
				PCF_OP_PMC: begin
					if (!ext[`PCF_EXT_PCU] && user_level(op.cpl)) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_GP;
					end
				end
				PCF_OP_TSC: begin
					if (ext[`PCF_EXT_TSR] && user_level(op.cpl)) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_GP;
					end
				end
				PCF_OP_DBG: begin
					if (op.dbg_idx == 3'h4 || op.dbg_idx == 3'h5) begin
						if (ext[`PCF_EXT_XBC]) begin
							verdict.fault  = 1'b1;
							verdict.vector = `PCF_VEC_IOP;
						end else begin
							verdict.dbg_idx_eff = op.dbg_idx + 3'h2; // legacy alias
						end
					end
				end
				PCF_OP_MEM: begin
					if (op.sup_wr_ro_user && scz[`PCF_SCZ_WP]) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_PF;
					end else if (op.misaligned && op.alignment_check_flag
							&& scz[`PCF_SCZ_ACM]) begin
						verdict.fault  = 1'b1;
						verdict.vector = `PCF_VEC_ALN;
					end
				end
				default: begin
				end
			endcase
		end
	end

endmodule // pcf_gate

// file: hw/pcf_ctrl.sv
`timescale 1ns/1ns
`include "pcf_map.svh"
module pcf_ctrl #(
	parameter int DATA_W = 32,
	parameter int PA_W   = 36
) (
	input  wire  logic                  clk_sys,
	input  wire  logic                  reset_n,
	input  wire  logic                  mov_we,
	input  wire  logic                  mov_re,
	input  wire  pcf_pkg::pcf_crsel_e   mov_sel,
	input  wire  logic [DATA_W-1:0]     mov_wdata,
	input  wire  pcf_pkg::pcf_op_s      op_req,
	input  wire  logic                  task_switch,
	input  wire  logic                  unpaged_cycle,
	input  wire  logic                  pte_pcd,
	input  wire  logic                  pte_pwt,
	input  wire  logic                  pde_ps,
	input  wire  logic [PA_W-1:0]       xlat_pa,
	input  wire  logic                  hw_error,
	input  wire  logic                  fp_error,
	output       logic [DATA_W-1:0]     rd_data,
	output       pcf_pkg::pcf_verdict_s verdict,
	output       pcf_pkg::pcf_mode_s    mode,
	output       pcf_pkg::pcf_cache_s   cache,
	output       logic                  page_cache_off_pin,
	output       logic                  page_write_through_pin,
	output       logic                  page_is_large,
	output       logic [PA_W-1:0]       pa_out,
	output       logic                  flush_all,
	output       logic                  flush_nonglobal,
	output       logic                  mc_raise,
	output       logic                  numeric_fault,
	output       logic                  fp_err_ext
);
	import pcf_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (DATA_W != 32) begin : g_bad_data_w
		$error("pcf_ctrl: DATA_W must be 32");
	end
	if (PA_W != 36) begin : g_bad_pa_w
		$error("pcf_ctrl: PA_W must be 36");
	end

	// ************************************************************
	// control registers
	// ************************************************************
	logic [31:0]  system_control_zero;
	logic [31:0]  page_base_control;
	logic [31:0]  extension_control;
	pcf_verdict_s next_verdict;

	// write strobes per register
	logic         wr_scz;
	logic         wr_pbc;
	logic         wr_ext;
	logic         paging_on;

	assign wr_scz    = mov_we && (mov_sel == PCF_SEL_SCZ);
	assign wr_pbc    = mov_we && (mov_sel == PCF_SEL_PBC);
	assign wr_ext    = mov_we && (mov_sel == PCF_SEL_EXT);
	assign paging_on = system_control_zero[`PCF_SCZ_PG];

	// system control zero; the task-switched bit is also set by hardware
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			system_control_zero <= `PCF_SCZ_RST;
		end else begin
			if (wr_scz) begin
				system_control_zero <= mov_wdata & `PCF_SCZ_WMASK;
			end
			// a task switch in the same cycle as a clearing write still sets it
			if (task_switch) begin
				system_control_zero[`PCF_SCZ_TSW] <= 1'b1;
			end
		end
	end

	// page base; only the base and the two attribute bits are kept
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			page_base_control <= `PCF_PBC_RST;
		end else if (wr_pbc) begin
			page_base_control <= mov_wdata & `PCF_PBC_WMASK;
		end
	end

	// extension control, all features off out of reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			extension_control <= `PCF_EXT_RST;
		end else if (wr_ext) begin
			extension_control <= mov_wdata & `PCF_EXT_WMASK;
		end
	end

	// ************************************************************
	// register read back
	// ************************************************************
	// reads return the value stored before any write in the same cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (mov_re) begin
			unique case (mov_sel)
				PCF_SEL_SCZ: rd_data <= system_control_zero;
				PCF_SEL_PBC: rd_data <= page_base_control;
				PCF_SEL_EXT: rd_data <= extension_control;
				default:     rd_data <= '0;
			endcase
		end
	end

	// ************************************************************
	// instruction gating
	// ************************************************************
	pcf_gate u_gate (
		.op      (op_req),
		.scz     (system_control_zero),
		.ext     (extension_control),
		.verdict (next_verdict)
	);

	// verdict appears one cycle after the request
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			verdict <= '0;
		end else begin
			verdict <= next_verdict;
		end
	end

	// ************************************************************
	// mode flags seen by the rest of the core
	// ************************************************************
	// registered copy lags the control registers by one cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode <= '0;
		end else begin
			mode.v86_interrupt_ext <= extension_control[`PCF_EXT_V86];
			mode.protected_virtual_irq <= extension_control[`PCF_EXT_PIRQ];
			mode.timestamp_read_restrict <= extension_control[`PCF_EXT_TSR];
			mode.extended_breakpoint_control <= extension_control[`PCF_EXT_XBC];
			mode.large_page_ext <= extension_control[`PCF_EXT_LPG];
			mode.wide_physical_address <= extension_control[`PCF_EXT_WPA];
			mode.hw_error_exception_on <= extension_control[`PCF_EXT_HWE];
			mode.global_page_keep <= extension_control[`PCF_EXT_GPK];
			mode.perf_counter_user_read <= extension_control[`PCF_EXT_PCU];
			mode.os_fpu_state_save <= extension_control[`PCF_EXT_OSF];
			mode.os_simd_fault_support <= extension_control[`PCF_EXT_OSX];
			mode.numeric_error_report <= system_control_zero[`PCF_SCZ_NER];
			mode.write_protect_on <= system_control_zero[`PCF_SCZ_WP];
			mode.alignment_check_mask <= system_control_zero[`PCF_SCZ_ACM];
		end
	end

	// ************************************************************
	// internal cache policy
	// ************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cache <= '0;
		end else begin
			cache.cache_enable     <= !system_control_zero[`PCF_SCZ_COF];
			cache.write_through_on <= !system_control_zero[`PCF_SCZ_NWT];
			cache.inval_cycles_on  <= !system_control_zero[`PCF_SCZ_NWT];
		end
	end

	// ************************************************************
	// page attribute pins toward the external cache
	// ************************************************************
	// unpaged cycles have no page entry, so the base register supplies both bits
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			page_cache_off_pin     <= 1'b0;
			page_write_through_pin <= 1'b0;
		end else if (!paging_on) begin
			page_cache_off_pin     <= 1'b0;
			page_write_through_pin <= 1'b0;
		end else if (unpaged_cycle) begin
			page_cache_off_pin     <= page_base_control[`PCF_PBC_COF];
			page_write_through_pin <= page_base_control[`PCF_PBC_WRT];
		end else begin
			page_cache_off_pin     <= pte_pcd;
			page_write_through_pin <= pte_pwt;
		end
	end

	// ************************************************************
	// translation width and page size
	// ************************************************************
	// narrow mode clears the four upper lines rather than faulting
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pa_out <= '0;
		end else if (extension_control[`PCF_EXT_WPA]) begin
			pa_out <= xlat_pa;
		end else begin
			pa_out <= {{(PA_W-`PCF_PA_NARROW){1'b0}}, xlat_pa[`PCF_PA_NARROW-1:0]};
		end
	end

	// large pages only honoured when the extension is on and paging runs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			page_is_large <= 1'b0;
		end else begin
			page_is_large <= pde_ps && paging_on && extension_control[`PCF_EXT_LPG];
		end
	end

	// ************************************************************
	// translation flushes
	// ************************************************************
	// a task switch or base reload flushes; global entries survive if kept
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flush_all       <= 1'b0;
			flush_nonglobal <= 1'b0;
		end else begin
			flush_all       <= (task_switch || wr_pbc) && !extension_control[`PCF_EXT_GPK];
			flush_nonglobal <= (task_switch || wr_pbc) && extension_control[`PCF_EXT_GPK];
		end
	end

	// ************************************************************
	// error reporting
	// ************************************************************
	// hardware errors are dropped silently while the exception is off
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mc_raise <= 1'b0;
		end else begin
			mc_raise <= hw_error && extension_control[`PCF_EXT_HWE];
		end
	end

	// numeric errors go native or out to the external error line
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			numeric_fault <= 1'b0;
			fp_err_ext    <= 1'b0;
		end else begin
			numeric_fault <= fp_error && system_control_zero[`PCF_SCZ_NER];
			fp_err_ext    <= fp_error && !system_control_zero[`PCF_SCZ_NER];
		end
	end

endmodule // pcf_ctrl

// file: verification/pcf_ctrl_monitor.sv
`timescale 1ns/1ns
module pcf_ctrl_monitor #(
	parameter int DATA_W = 32,
	parameter int PA_W   = 36
) (
	input wire logic                  clk_sys,
	input wire logic                  reset_n,
	input wire logic                  mov_we,
	input wire pcf_pkg::pcf_crsel_e   mov_sel,
	input wire logic [DATA_W-1:0]     mov_wdata,
	input wire pcf_pkg::pcf_op_s      op_req,
	input wire logic                  task_switch,
	input wire logic [PA_W-1:0]       xlat_pa,
	input wire logic                  hw_error,
	input wire pcf_pkg::pcf_verdict_s verdict,
	input wire pcf_pkg::pcf_mode_s    mode,
	input wire pcf_pkg::pcf_cache_s   cache,
	input wire logic [PA_W-1:0]       pa_out,
	input wire logic                  flush_all,
	input wire logic                  flush_nonglobal,
	input wire logic                  mc_raise
);
	import pcf_pkg::*;
	// ****************
	// helper state
	// ****************
	logic [2:0] wr_hist;
	logic       off_seen;
	logic       wt_seen;
	logic       quiet;
	// flag copies trail the registers, so checks wait for three write-free cycles
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) wr_hist <= 3'h7;
		else wr_hist <= {wr_hist[1:0], mov_we};
	end
	// last cache flags written to the system control register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			off_seen <= 1'b0;
			wt_seen  <= 1'b0;
		end else if (mov_we && mov_sel == PCF_SEL_SCZ) begin
			off_seen <= mov_wdata[30];
			wt_seen  <= mov_wdata[29];
		end
	end
	assign quiet = (wr_hist == 3'h0);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// ****************
	// properties
	// ****************
	a_ext_reset_clear: assert property (
		$rose(reset_n) |-> mode == '0 ##1 mode == '0
	) else $error("flag copies not clear after reset");
	a_tsc_priv_gate: assert property (
		op_req.valid && op_req.kind == PCF_OP_TSC && quiet |=> verdict.fault ==
		($past(mode.timestamp_read_restrict) && $past(op_req.cpl) != 2'h0)
		&& (!verdict.fault || verdict.vector == 8'h0D)
	) else $error("time-stamp read gate wrong");
	a_pmc_any_level: assert property (
		op_req.valid && op_req.kind == PCF_OP_PMC && quiet |=> verdict.fault ==
		(!$past(mode.perf_counter_user_read) && $past(op_req.cpl) != 2'h0)
	) else $error("counter read gate wrong");
	a_dbg_alias_fault: assert property (
		op_req.valid && op_req.kind == PCF_OP_DBG && op_req.dbg_idx[2:1] == 2'h2 && quiet
		|=> $past(mode.extended_breakpoint_control) ? verdict.vector == 8'h06 && verdict.fault
		: !verdict.fault && verdict.dbg_idx_eff == $past(op_req.dbg_idx) + 3'h2
	) else $error("debug alias handling wrong");
	a_write_protect_ro: assert property (
		op_req.valid && op_req.kind == PCF_OP_MEM && op_req.sup_wr_ro_user
		&& mode.write_protect_on && quiet |=> verdict.fault && verdict.vector == 8'h0E
	) else $error("read-only user page not protected");
	a_align_needs_both: assert property (
		op_req.valid && op_req.kind == PCF_OP_MEM && !op_req.sup_wr_ro_user && quiet
		|=> verdict.fault == $past(op_req.misaligned && op_req.alignment_check_flag
		&& mode.alignment_check_mask)
	) else $error("alignment check gating wrong");
	a_cache_follows: assert property (
		quiet |-> cache == {!off_seen, !wt_seen, !wt_seen}
	) else $error("cache controls do not follow flags");
	a_pa_width_cap: assert property (
		quiet && !mode.wide_physical_address |=> pa_out[PA_W-1:32] == '0
		&& pa_out[31:0] == $past(xlat_pa[31:0])
	) else $error("narrow physical address wrong");
	a_flush_global_keep: assert property (
		task_switch && quiet |=> flush_nonglobal == $past(mode.global_page_keep)
		&& flush_all == !$past(mode.global_page_keep)
	) else $error("task switch flush kind wrong");
	a_mc_gate: assert property (
		hw_error && quiet |=> mc_raise == $past(mode.hw_error_exception_on)
	) else $error("machine check gating wrong");
	c_tsc_fault: cover property (verdict.fault && verdict.vector == 8'h0D);
	c_dbg_fault: cover property (verdict.fault && verdict.vector == 8'h06);
	c_flush_keep: cover property (flush_nonglobal);
endmodule // pcf_ctrl_monitor

bind pcf_ctrl pcf_ctrl_monitor #(.DATA_W(DATA_W), .PA_W(PA_W)) u_monitor (
	.clk_sys, .reset_n, .mov_we, .mov_sel, .mov_wdata, .op_req, .task_switch, .xlat_pa,
	.hw_error, .verdict, .mode, .cache, .pa_out, .flush_all, .flush_nonglobal, .mc_raise
);

// file: verification/pcf_cache_agent.sv
`timescale 1ns/1ns
module pcf_cache_agent (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic page_cache_off_pin,
	input  wire logic page_write_through_pin,
	output      logic seen_off,
	output      logic seen_wt
);
	// external cache latches the attribute pins of every bus cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			seen_off <= 1'b0;
			seen_wt  <= 1'b0;
		end else begin
			seen_off <= page_cache_off_pin;
			seen_wt  <= page_write_through_pin;
		end
	end
endmodule // pcf_cache_agent

// file: verification/processor_control_flags_bench.sv
`timescale 1ns/1ns
module processor_control_flags_bench;
	import pcf_pkg::*;
	logic         clk_sys, reset_n, mov_we, mov_re, task_switch, unpaged_cycle;
	logic         pte_pcd, pte_pwt, pde_ps, hw_error, fp_error, page_is_large;
	logic         page_cache_off_pin, page_write_through_pin, flush_all, flush_nonglobal;
	logic         mc_raise, numeric_fault, fp_err_ext, seen_off, seen_wt;
	logic [31:0]  mov_wdata, rd_data;
	logic [35:0]  xlat_pa, pa_out;
	pcf_crsel_e   mov_sel;
	pcf_op_s      op_req;
	pcf_verdict_s verdict, v;
	pcf_mode_s    mode;
	pcf_cache_s   cache;
	int           fails = 0;
	int           checks = 0;

	pcf_ctrl uut (.clk_sys, .reset_n, .mov_we, .mov_re, .mov_sel, .mov_wdata, .op_req,
		.task_switch, .unpaged_cycle, .pte_pcd, .pte_pwt, .pde_ps, .xlat_pa, .hw_error,
		.fp_error, .rd_data, .verdict, .mode, .cache, .page_cache_off_pin,
		.page_write_through_pin, .page_is_large, .pa_out, .flush_all, .flush_nonglobal,
		.mc_raise, .numeric_fault, .fp_err_ext);
	pcf_cache_agent agent (.clk_sys, .reset_n, .page_cache_off_pin, .page_write_through_pin,
		.seen_off, .seen_wt);

	// 20 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe, then two idle cycles so the flag copies catch up
	task automatic wr(input pcf_crsel_e s, input logic [31:0] d);
		@(posedge clk_sys);
		mov_we <= 1'b1;
		mov_sel <= s;
		mov_wdata <= d;
		@(posedge clk_sys);
		mov_we <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input pcf_crsel_e s, input logic [31:0] exp);
		@(posedge clk_sys);
		mov_re <= 1'b1;
		mov_sel <= s;
		@(posedge clk_sys);
		mov_re <= 1'b0;
		@(posedge clk_sys);
		#1 chk(rd_data, exp);
	endtask
	// one operation; the verdict stands only in the following cycle
	task automatic opc(input pcf_op_e k, input logic [1:0] c, input logic [2:0] ix,
			input logic [2:0] m, input logic f, input logic [7:0] vec);
		@(posedge clk_sys);
		op_req <= {1'b1, k, c, ix, m};
		@(posedge clk_sys);
		op_req <= '0;
		#1 v = verdict;
		chk(v.fault, f);
		if (f) chk(v.vector, vec);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse_all(input logic on);
		@(posedge clk_sys);
		hw_error <= 1'b1;
		task_switch <= 1'b1;
		fp_error <= 1'b1;
		@(posedge clk_sys);
		hw_error <= 1'b0;
		task_switch <= 1'b0;
		fp_error <= 1'b0;
		#1 chk(mc_raise, on);
		chk({flush_nonglobal, flush_all}, {on, !on});
		chk({numeric_fault, fp_err_ext}, {on, !on});
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_regs;
		rd(PCF_SEL_EXT, 32'h0);
		wr(PCF_SEL_EXT, 32'hFFFFFFFF);
		rd(PCF_SEL_EXT, 32'h000007FF);
		chk({mode.os_simd_fault_support, mode.os_fpu_state_save}, 2'h3);
		chk({mode.v86_interrupt_ext, mode.protected_virtual_irq}, 2'h3);
		wr(PCF_SEL_SCZ, 32'hFFFFFFFF);
		rd(PCF_SEL_SCZ, 32'hE005002F);
		chk(mode, 14'h3FFF);
		wr(PCF_SEL_PBC, 32'hFFFFFFFF);
		rd(PCF_SEL_PBC, 32'hFFFFF018);
		// a second reset mid-run must wipe the extension flags again
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(PCF_SEL_EXT, 32'h0);
		$display("register test done");
	endtask
	task automatic t_fp;
		for (int i = 0; i < 4; i++) begin
			wr(PCF_SEL_SCZ, {29'h0, i[1], i[0], 1'b0});
			opc(PCF_OP_FP, 2'h0, 3'h0, 3'h0, i[1], 8'h07);
			chk(v.fpu_issue, !i[1]);
			@(posedge clk_sys);
			task_switch <= 1'b1;
			@(posedge clk_sys);
			task_switch <= 1'b0;
			opc(PCF_OP_WAIT, 2'h0, 3'h0, 3'h0, i[0], 8'h07);
		end
		wr(PCF_SEL_SCZ, 32'h00000002);
		opc(PCF_OP_WAIT, 2'h0, 3'h0, 3'h0, 1'b0, 8'h07);
		$display("float mode test done");
	endtask
	task automatic t_priv;
		for (int i = 0; i < 4; i++) begin
			wr(PCF_SEL_EXT, {23'h0, i[0], 5'h0, i[1], 2'h0});
			opc(PCF_OP_PMC, 2'h3, 3'h0, 3'h0, !i[0], 8'h0D);
			opc(PCF_OP_PMC, 2'h0, 3'h0, 3'h0, 1'b0, 8'h0D);
			opc(PCF_OP_TSC, 2'h3, 3'h0, 3'h0, i[1], 8'h0D);
			opc(PCF_OP_TSC, 2'h0, 3'h0, 3'h0, 1'b0, 8'h0D);
		end
		$display("privilege test done");
	endtask
	task automatic t_dbg;
		for (int i = 0; i < 4; i++) begin
			wr(PCF_SEL_EXT, {28'h0, i[1], 3'h0});
			opc(PCF_OP_DBG, 2'h0, {2'h2, i[0]}, 3'h0, i[1], 8'h06);
			if (!i[1]) chk(v.dbg_idx_eff, {2'h3, i[0]});
		end
		$display("debug alias test done");
	endtask
	task automatic t_mem;
		for (int i = 0; i < 8; i++) begin
			wr(PCF_SEL_SCZ, {13'h0, i[1], 1'b0, i[0], 16'h0});
			opc(PCF_OP_MEM, 2'h0, 3'h0, {1'b1, i[2], 1'b1}, i[0] | (i[1] & i[2]),
				i[0] ? 8'h0E : 8'h11);
			opc(PCF_OP_MEM, 2'h3, 3'h0, {1'b1, i[2], 1'b0}, i[1] & i[2], 8'h11);
		end
		$display("memory check test done");
	endtask
	task automatic t_pins;
		for (int i = 0; i < 4; i++) begin
			wr(PCF_SEL_SCZ, {1'b1, i[1], i[0], 29'h0});
			chk(cache, {!i[1], !i[0], !i[0]});
		end
		@(posedge clk_sys);
		unpaged_cycle <= 1'b1;
		pte_pwt <= 1'b1;
		wr(PCF_SEL_PBC, 32'h00000010);
		settle;
		chk({seen_off, seen_wt}, 2'h2);
		wr(PCF_SEL_PBC, 32'h00000008);
		settle;
		chk({seen_off, seen_wt}, 2'h1);
		@(posedge clk_sys);
		unpaged_cycle <= 1'b0;
		pte_pcd <= 1'b1;
		settle;
		chk({seen_off, seen_wt}, 2'h3);
		// paging off: pins stay low even on an unpaged cycle
		@(posedge clk_sys);
		unpaged_cycle <= 1'b1;
		wr(PCF_SEL_SCZ, 32'h0);
		settle;
		chk({seen_off, seen_wt}, 2'h0);
		$display("attribute pin test done");
	endtask
	task automatic t_events;
		for (int i = 0; i < 2; i++) begin
			wr(PCF_SEL_SCZ, {26'h2000000, i[0], 5'h0});
			wr(PCF_SEL_EXT, {24'h0, {4{i[0]}}, 4'h0});
			@(posedge clk_sys);
			xlat_pa <= 36'hF12345678;
			pde_ps <= 1'b1;
			settle;
			chk(pa_out, i[0] ? 36'hF12345678 : 36'h012345678);
			chk(page_is_large, i[0]);
			chk(mode, i[0] ? 14'h3C4 : 14'h000);
			pulse_all(i[0]);
		end
		$display("event test done");
	endtask

	task automatic stop_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{mov_we, mov_re, task_switch, unpaged_cycle, pte_pcd, pte_pwt} = '0;
		{pde_ps, hw_error, fp_error, reset_n} = '0;
		mov_sel = PCF_SEL_SCZ;
		mov_wdata = '0;
		op_req = '0;
		xlat_pa = '0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs;
		t_fp;
		t_priv;
		t_dbg;
		t_mem;
		t_pins;
		t_events;
		stop_test;
	end
	// watchdog: the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		stop_test;
	end
endmodule // processor_control_flags_bench
